// [rtl/idh_pkg.sv]
package idh_pkg;

    // Avalon byte offsets of the register file
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CSR_TX   = 8'h04;
    localparam logic [7:0] OFS_CSR_RX   = 8'h08;
    localparam logic [7:0] OFS_PIO_LO   = 8'h0C;
    localparam logic [7:0] OFS_PIO_HDR  = 8'h10;
    localparam logic [7:0] OFS_INV_HI   = 8'h14;
    localparam logic [7:0] OFS_IRQ_ANS  = 8'h18;
    localparam logic [7:0] OFS_WRACK    = 8'h1C;
    localparam logic [7:0] OFS_INJECT   = 8'h20;
    localparam logic [7:0] OFS_STATUS   = 8'h24;
    localparam logic [7:0] OFS_MASK     = 8'h28;
    localparam logic [7:0] OFS_SYNDROME = 8'h2C;
    localparam logic [7:0] OFS_BANK_EN  = 8'h30;
    localparam logic [7:0] OFS_HASH     = 8'h34;
    localparam logic [7:0] OFS_PKT_DATA = 8'h38;
    localparam logic [7:0] OFS_PKT_STAT = 8'h3C;

    // Hub CSR address whose write launches a translation invalidate
    localparam logic [39:0] XLATE_INV_CSR_ADDR = 40'h80_0000_2030;

    // Field positions
    localparam int IRQ_ID_W      = 6;
    localparam int IRQ_ACK_BIT   = 8;
    localparam int IRQ_NACK_BIT  = 9;
    localparam int CTRL_GNT_BIT  = 0;
    localparam int WRACK_CNT_LSB = 8;
    localparam int SYN_VLD_BIT   = 4;

    // Sticky status layout
    localparam int DMA_ERR_W     = 6;
    localparam int SII_ERR_W     = 8;
    localparam int ST_DMA_LSB    = 0;
    localparam int ST_SII_LSB    = 6;
    localparam int ST_WRACK_PE   = 14;
    localparam int ST_PKT_PE     = 15;
    localparam int ST_PKT_RDY    = 16;
    localparam int ST_WRACK      = 17;
    localparam int ST_CSR_RX     = 18;
    localparam int STS_W         = 19;
    localparam int INJ_W         = DMA_ERR_W + SII_ERR_W;

    // Reset values and inbound packet length
    localparam logic [4:0] BANK_RST  = 5'h0F;
    localparam logic       HASH_RST  = 1'b0;
    localparam logic       GNT_RST   = 1'b1;
    localparam int         PKT_WORDS = 4;

    typedef struct packed {
        logic vld;
        logic [31:0] data;
    } idh_word_t;

    typedef struct packed {
        logic int_err;
        logic ncucr_pe;
        logic siicr_pe;
        logic data_pe;
        logic tag_ce;
        logic tag_ue;
    } idh_dma_err_t;

    typedef struct packed {
        logic niu_data_pe;
        logic niu_tag_ce;
        logic niu_tag_ue;
        logic niu_addr_ue;
        logic dma_data_pe;
        logic dma_tag_ce;
        logic dma_tag_ue;
        logic dma_addr_ue;
    } idh_sii_err_t;

    typedef struct packed {
        logic bank_partial_flag;
        logic bank_pair_6_7_avail;
        logic bank_pair_4_5_avail;
        logic bank_pair_2_3_avail;
        logic bank_pair_0_1_avail;
    } idh_bank_t;

    // Odd parity holds when data and parity bit hold an odd count of ones
    function automatic logic idh_odd_ok(input logic [31:0] d,
                                        input logic p);
        return ^{d, p};
    endfunction

endpackage

// [rtl/idh_pkt_rx.sv]
`timescale 1ns/100ps
module idh_pkt_rx #(
    parameter int WORDS = idh_pkg::PKT_WORDS
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              enable_i,
    input  wire logic              req_i,
    input  wire logic [31:0]       data_i,
    input  wire logic [1:0]        dpar_i,
    input  wire logic              pop_i,
    output logic                   gnt_o,
    output logic [31:0]            word_o,
    output logic                   ready_o,
    output logic                   perr_o,
    output logic                   done_o
);
    import idh_pkg::*;

    localparam int IW = $clog2(WORDS + 1);

    typedef enum logic [1:0] {S_IDLE, S_GNT, S_DATA, S_HOLD} idh_rx_st_t;

    typedef struct packed {
        idh_rx_st_t              st;
        logic [IW-1:0]           cnt;
        logic [WORDS-1:0][31:0]  mem;
        logic                    perr;
        logic                    done;
    } idh_rx_t;

    idh_rx_t r_r;
    idh_rx_t r_nxt;
    logic    ok_even;
    logic    ok_odd;

    // Even bits checked against parity bit 0, odd bits against bit 1
    always_comb begin
        logic [31:0] ev;
        logic [31:0] od;
        ev = '0;
        od = '0;
        for (int i = 0; i < 16; i++) begin
            ev[i] = data_i[2*i];
            od[i] = data_i[2*i+1];
        end
        ok_even = idh_odd_ok(ev, dpar_i[0]);
        ok_odd  = idh_odd_ok(od, dpar_i[1]);
    end

    // Grant only with the whole buffer free; data follows next cycle
    always_comb begin
        r_nxt      = r_r;
        r_nxt.perr = 1'b0;
        r_nxt.done = 1'b0;
        case (r_r.st)
            S_IDLE: begin
                if (enable_i && req_i) begin
                    r_nxt.st = S_GNT;
                end
            end
            S_GNT: begin
                r_nxt.st  = S_DATA;
                r_nxt.cnt = '0;
            end
            S_DATA: begin
                r_nxt.mem[r_r.cnt[IW-1:0]] = data_i;
                r_nxt.perr = !(ok_even && ok_odd);
                if (r_r.cnt == IW'(WORDS - 1)) begin
                    r_nxt.st   = S_HOLD;
                    r_nxt.cnt  = '0;
                    r_nxt.done = 1'b1;
                end else begin
                    r_nxt.cnt = r_r.cnt + IW'(1);
                end
            end
            default: begin
                if (pop_i) begin
                    if (r_r.cnt == IW'(WORDS - 1)) begin
                        r_nxt.st  = S_IDLE;
                        r_nxt.cnt = '0;
                    end else begin
                        r_nxt.cnt = r_r.cnt + IW'(1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign gnt_o   = (r_r.st == S_GNT);
    assign ready_o = (r_r.st == S_HOLD);
    assign word_o  = r_r.mem[r_r.cnt[IW-1:0]];
    assign perr_o  = r_r.perr;
    assign done_o  = r_r.done;
endmodule

// [rtl/idh_hub.sv]
`timescale 1ns/100ps
module idh_hub (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    // Avalon-MM slave
    input  wire logic [7:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o,
    output logic                       irq_o,
    // Config path toward and from the DMA unit
    output idh_pkg::idh_word_t         csr_tx_o,
    input  wire logic                  csr_tx_stall_i,
    input  wire idh_pkg::idh_word_t    csr_rx_i,
    output logic                       csr_rx_stall_o,
    // Programmed I/O and interrupt answer
    output logic [63:0]                pio_data_o,
    output logic                       pio_hdr_vld_o,
    output logic                       xlate_addr_vld_o,
    input  wire logic                  wrack_vld_i,
    input  wire logic [3:0]            wrack_tag_i,
    input  wire logic                  wrack_par_i,
    output logic                       irq_ack_o,
    output logic                       irq_nack_o,
    output logic [5:0]                 irq_msg_ident_o,
    // DMA error strobes and injections
    input  wire idh_pkg::idh_dma_err_t dma_err_i,
    output idh_pkg::idh_dma_err_t      dma_inj_o,
    // Inbound interface unit
    output logic                       in_gnt_o,
    input  wire logic                  in_req_i,
    input  wire logic [31:0]           in_data_i,
    input  wire logic [1:0]            in_dparity_i,
    input  wire idh_pkg::idh_sii_err_t sii_err_i,
    output idh_pkg::idh_sii_err_t      sii_inj_o,
    input  wire logic                  syn_vld_i,
    input  wire logic [3:0]            syn_data_i,
    output idh_pkg::idh_bank_t         bank_o,
    output logic                       index_hash_enable_o
);
    import idh_pkg::*;

    typedef struct packed {
        logic              rd_pend;
        logic [31:0]       rdata;
        logic              tx_full;
        logic [31:0]       tx_data;
        logic              rx_full;
        logic [31:0]       rx_data;
        logic [31:0]       pio_lo;
        logic [63:0]       pio_data;
        logic              hdr_vld;
        logic              inv_vld;
        logic              ack;
        logic              nack;
        logic [5:0]        irq_id;
        logic [3:0]        wrack_tag;
        logic [7:0]        wrack_cnt;
        logic [4:0]        syn;
        logic [STS_W-1:0]  sts;
        logic [STS_W-1:0]  mask;
        logic [INJ_W-1:0]  error_injection_reg;
        logic [4:0]        bank_en;
        logic              index_hash_state_reg;
        logic              gnt_en;
    } idh_hub_st_t;

    idh_hub_st_t s_r;
    idh_hub_st_t s_nxt;

    logic        wr_go;
    logic        rd_go;
    logic        tx_blocked;
    logic [31:0] pkt_word;
    logic        pkt_ready;
    logic        pkt_perr;
    logic        pkt_done;
    logic        pkt_pop;

    // Writes to a full transmit holding word wait instead of overwriting
    assign tx_blocked = avs_write_i && (avs_address_i == OFS_CSR_TX)
                        && s_r.tx_full;
    assign wr_go      = avs_write_i && !tx_blocked;
    assign rd_go      = avs_read_i && s_r.rd_pend;
    assign avs_waitrequest_o = (avs_read_i && !s_r.rd_pend) || tx_blocked;
    assign pkt_pop    = rd_go && (avs_address_i == OFS_PKT_DATA)
                        && pkt_ready;

    // Inbound packet buffer with grant and parity check
    idh_pkt_rx #(
        .WORDS    (PKT_WORDS)
    ) u_pkt_rx (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .enable_i (s_r.gnt_en),
        .req_i    (in_req_i),
        .data_i   (in_data_i),
        .dpar_i   (in_dparity_i),
        .pop_i    (pkt_pop),
        .gnt_o    (in_gnt_o),
        .word_o   (pkt_word),
        .ready_o  (pkt_ready),
        .perr_o   (pkt_perr),
        .done_o   (pkt_done)
    );

    // Main next-state process; reads take two cycles so data is registered
    always_comb begin
        logic [STS_W-1:0] set;
        logic [STS_W-1:0] clr;
        logic [31:0]      rv;
        set   = '0;
        clr   = '0;
        rv    = '0;
        s_nxt = s_r;

        // Single-cycle strobes fall back by default
        s_nxt.hdr_vld = 1'b0;
        s_nxt.inv_vld = 1'b0;
        s_nxt.ack     = 1'b0;
        s_nxt.nack    = 1'b0;

        // Outbound config word leaves when the DMA side is not stalling
        if (s_r.tx_full && !csr_tx_stall_i) begin
            s_nxt.tx_full = 1'b0;
        end

        // Inbound config word taken only while our stall is low
        if (csr_rx_i.vld && !s_r.rx_full) begin
            s_nxt.rx_full = 1'b1;
            s_nxt.rx_data = csr_rx_i.data;
            set[ST_CSR_RX] = 1'b1;
        end

        // Write credit return with odd parity over the four tag bits
        if (wrack_vld_i) begin
            s_nxt.wrack_tag = wrack_tag_i;
            s_nxt.wrack_cnt = s_r.wrack_cnt + 8'h01;
            set[ST_WRACK]   = 1'b1;
            set[ST_WRACK_PE] = !(^{wrack_tag_i, wrack_par_i});
        end

        // Syndrome captured with its valid flag
        if (syn_vld_i) begin
            s_nxt.syn = {1'b1, syn_data_i};
        end

        // Error strobes from both neighbours, plus packet parity error and packet done
        set[ST_DMA_LSB +: DMA_ERR_W] = dma_err_i;
        set[ST_SII_LSB +: SII_ERR_W] = sii_err_i;
        set[ST_PKT_PE]  = pkt_perr;
        set[ST_PKT_RDY] = pkt_done;

        // Read address decode
        if (avs_address_i == OFS_CTRL) begin
            rv[CTRL_GNT_BIT] = s_r.gnt_en;
        end else if (avs_address_i == OFS_CSR_TX) begin
            rv = s_r.tx_data;
        end else if (avs_address_i == OFS_CSR_RX) begin
            rv = s_r.rx_data;
        end else if (avs_address_i == OFS_PIO_LO) begin
            rv = s_r.pio_lo;
        end else if (avs_address_i == OFS_PIO_HDR) begin
            rv = s_r.pio_data[63:32];
        end else if (avs_address_i == OFS_INV_HI) begin
            rv = s_r.pio_data[63:32];
        end else if (avs_address_i == OFS_IRQ_ANS) begin
            rv[IRQ_ID_W-1:0] = s_r.irq_id;
        end else if (avs_address_i == OFS_WRACK) begin
            rv[3:0] = s_r.wrack_tag;
            rv[WRACK_CNT_LSB +: 8] = s_r.wrack_cnt;
        end else if (avs_address_i == OFS_INJECT) begin
            rv[INJ_W-1:0] = s_r.error_injection_reg;
        end else if (avs_address_i == OFS_STATUS) begin
            rv[STS_W-1:0] = s_r.sts;
        end else if (avs_address_i == OFS_MASK) begin
            rv[STS_W-1:0] = s_r.mask;
        end else if (avs_address_i == OFS_SYNDROME) begin
            rv[SYN_VLD_BIT:0] = s_r.syn;
        end else if (avs_address_i == OFS_BANK_EN) begin
            rv[4:0] = s_r.bank_en;
        end else if (avs_address_i == OFS_HASH) begin
            rv[0] = s_r.index_hash_state_reg;
        end else if (avs_address_i == OFS_PKT_DATA) begin
            rv = pkt_ready ? pkt_word : 32'h0000_0000;
        end else if (avs_address_i == OFS_PKT_STAT) begin
            rv[0] = pkt_ready;
            rv[1] = in_gnt_o;
        end else begin
            rv = 32'h0000_0000; // Unmapped reads return zero
        end

        // Read phase one latches data, phase two completes with side effects
        if (avs_read_i && !s_r.rd_pend) begin
            s_nxt.rd_pend = 1'b1;
            s_nxt.rdata   = rv;
        end else if (rd_go) begin
            s_nxt.rd_pend = 1'b0;
            if (avs_address_i == OFS_CSR_RX) begin
                s_nxt.rx_full = 1'b0; // Frees the inbound word
            end else if (avs_address_i == OFS_SYNDROME) begin
                s_nxt.syn[SYN_VLD_BIT] = syn_vld_i;
            end
        end

        // Write address decode; unmapped writes are dropped
        if (wr_go) begin
            if (avs_address_i == OFS_CTRL) begin
                s_nxt.gnt_en = avs_writedata_i[CTRL_GNT_BIT];
            end else if (avs_address_i == OFS_CSR_TX) begin
                s_nxt.tx_full = 1'b1;
                s_nxt.tx_data = avs_writedata_i;
            end else if (avs_address_i == OFS_PIO_LO) begin
                s_nxt.pio_lo = avs_writedata_i;
            end else if (avs_address_i == OFS_PIO_HDR) begin
                s_nxt.pio_data = {avs_writedata_i, s_r.pio_lo};
                s_nxt.hdr_vld  = 1'b1;
            end else if (avs_address_i == OFS_INV_HI) begin
                s_nxt.pio_data = {avs_writedata_i, s_r.pio_lo};
                s_nxt.inv_vld  = 1'b1;
            end else if (avs_address_i == OFS_IRQ_ANS) begin
                s_nxt.irq_id = avs_writedata_i[IRQ_ID_W-1:0];
                s_nxt.ack    = avs_writedata_i[IRQ_ACK_BIT];
                s_nxt.nack   = avs_writedata_i[IRQ_NACK_BIT]
                               && !avs_writedata_i[IRQ_ACK_BIT];
            end else if (avs_address_i == OFS_INJECT) begin
                s_nxt.error_injection_reg = avs_writedata_i[INJ_W-1:0];
            end else if (avs_address_i == OFS_STATUS) begin
                clr = avs_writedata_i[STS_W-1:0];
            end else if (avs_address_i == OFS_MASK) begin
                s_nxt.mask = avs_writedata_i[STS_W-1:0];
            end else if (avs_address_i == OFS_BANK_EN) begin
                s_nxt.bank_en = avs_writedata_i[4:0];
            end else if (avs_address_i == OFS_HASH) begin
                s_nxt.index_hash_state_reg = avs_writedata_i[0];
            end
        end

        // A new event beats a simultaneous write-one-to-clear
        s_nxt.sts = (s_r.sts & ~clr) | set;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r                      <= '0;
            s_r.bank_en              <= BANK_RST;
            s_r.index_hash_state_reg <= HASH_RST;
            s_r.gnt_en               <= GNT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Register-driven outputs
    assign avs_readdata_o   = s_r.rdata;
    assign irq_o            = |(s_r.sts & s_r.mask);
    assign csr_tx_o.vld     = s_r.tx_full;
    assign csr_tx_o.data    = s_r.tx_data;
    assign csr_rx_stall_o   = s_r.rx_full;
    assign pio_data_o       = s_r.pio_data;
    assign pio_hdr_vld_o    = s_r.hdr_vld;
    assign xlate_addr_vld_o = s_r.inv_vld;
    assign irq_ack_o        = s_r.ack;
    assign irq_nack_o       = s_r.nack;
    assign irq_msg_ident_o  = s_r.irq_id;

    // Injection levels come straight from the injection register
    assign dma_inj_o = s_r.error_injection_reg[DMA_ERR_W-1:0];
    assign sii_inj_o = s_r.error_injection_reg[INJ_W-1:DMA_ERR_W];

    // Steady levels toward the inbound unit
    assign bank_o              = s_r.bank_en;
    assign index_hash_enable_o = s_r.index_hash_state_reg;
endmodule

// [verif/idh_hub_props.sv]
`timescale 1ns/100ps
module idh_hub_props
    import idh_pkg::*;
(
    input logic         clk_i,
    input logic         srst_i,
    input logic [7:0]   avs_address_i,
    input logic         avs_write_i,
    input logic [31:0]  avs_writedata_i,
    input logic         avs_waitrequest_o,
    input idh_word_t    csr_tx_o,
    input logic         csr_tx_stall_i,
    input logic         pio_hdr_vld_o,
    input logic         xlate_addr_vld_o,
    input logic         irq_ack_o,
    input logic         irq_nack_o,
    input logic [5:0]   irq_msg_ident_o,
    input idh_dma_err_t dma_inj_o,
    input idh_sii_err_t sii_inj_o,
    input logic         in_gnt_o,
    input idh_bank_t    bank_o,
    input logic         index_hash_enable_o
);
    logic [7:0] wa;
    logic [31:0] wd;
    // Address of a taken write, FF (unmapped) otherwise
    assign wa = (avs_write_i && !avs_waitrequest_o) ? avs_address_i : 8'hFF;
    assign wd = avs_writedata_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // Single-cycle strobes, no stretching
    sequence s_hdr_once;
        pio_hdr_vld_o ##1 !pio_hdr_vld_o;
    endsequence
    sequence s_inv_once;
        xlate_addr_vld_o ##1 !xlate_addr_vld_o;
    endsequence
    a_hdr_strobe: assert property (
        wa == OFS_PIO_HDR |=> s_hdr_once) else $error("hdr strobe wrong");
    a_inv_strobe: assert property (
        wa == OFS_INV_HI |=> s_inv_once) else $error("inv strobe wrong");
    a_tx_hold: assert property (
        csr_tx_o.vld && csr_tx_stall_i |=> $stable(csr_tx_o))
        else $error("tx word moved while stalled");
    a_ack_ident: assert property (
        wa == OFS_IRQ_ANS && wd[IRQ_ACK_BIT] |=> irq_ack_o && !irq_nack_o
        && irq_msg_ident_o == $past(wd[5:0])) else $error("ack wrong");
    a_nack_ident: assert property (
        wa == OFS_IRQ_ANS && !wd[IRQ_ACK_BIT] && wd[IRQ_NACK_BIT] |=>
        irq_nack_o && !irq_ack_o && irq_msg_ident_o == $past(wd[5:0]))
        else $error("nack wrong");
    a_bank_copy: assert property (
        wa == OFS_BANK_EN |=> bank_o == $past(wd[4:0]))
        else $error("bank levels wrong");
    a_hash_copy: assert property (
        wa == OFS_HASH |=> index_hash_enable_o == $past(wd[0]))
        else $error("hash level wrong");
    a_inj_copy: assert property (
        wa == OFS_INJECT |=> dma_inj_o == $past(wd[5:0])
        && sii_inj_o == $past(wd[13:6])) else $error("inject wrong");
    a_gnt_spacing: assert property (
        in_gnt_o |=> !in_gnt_o [*4]) else $error("grant too soon");
endmodule
bind idh_hub idh_hub_props u_idh_hub_props (.*);

// [verif/idh_far_model.sv]
`timescale 1ns/100ps
module idh_far_model (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        gnt_i,
    input  wire logic        go_i,
    input  wire logic        bad_i,
    output logic             req_o,
    output logic [31:0]      data_o,
    output logic [1:0]       dpar_o
);
    int          beat;
    logic [31:0] tick;
    // Request holds until grant, then four beats follow it
    always @(posedge clk_i) begin
        tick <= tick + 32'h1;
        if (srst_i) begin
            req_o <= 1'b0;
            beat <= 0;
            tick <= 32'h0;
        end else begin
            if (go_i) req_o <= 1'b1;
            if (gnt_i) begin
                req_o <= 1'b0;
                beat <= 1;
            end else if (beat != 0) begin
                beat <= (beat == 4) ? 0 : beat + 1;
            end
        end
    end
    // Idle bus toggles so a stale value is never mistaken for data
    always_comb begin
        data_o = (beat != 0) ? 32'hC0DE_0000 + beat : ~tick;
        dpar_o[0] = ~^(data_o & 32'h5555_5555);
        dpar_o[1] = ~^(data_o & 32'hAAAA_AAAA);
        if (bad_i && beat == 2) dpar_o[0] = ~dpar_o[0];
    end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    num_errors++; $display("[ERR] %0t got %0h exp %0h", $time, got, exp); \
    end end
module tb_top;
    import idh_pkg::*;
    logic         clk_i = 1'b0, srst_i = 1'b1;
    logic [7:0]   avs_address_i = 8'h00;
    logic         avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [31:0]  avs_writedata_i = 32'h0, avs_readdata_o, rd;
    logic [3:0]   avs_byteenable_i = 4'hF, wrack_tag_i = 4'h0;
    logic [3:0]   syn_data_i = 4'h0;
    logic         avs_waitrequest_o, irq_o, csr_rx_stall_o, in_gnt_o;
    logic         csr_tx_stall_i = 1'b0, wrack_vld_i = 1'b0;
    logic         wrack_par_i = 1'b0, syn_vld_i = 1'b0, go = 1'b0, bad = 1'b0;
    idh_word_t    csr_tx_o, csr_rx_i = '0;
    logic [63:0]  pio_data_o;
    logic         pio_hdr_vld_o, xlate_addr_vld_o, irq_ack_o, irq_nack_o;
    logic [5:0]   irq_msg_ident_o;
    idh_dma_err_t dma_err_i = '0, dma_inj_o;
    idh_sii_err_t sii_err_i = '0, sii_inj_o;
    logic         in_req_i, index_hash_enable_o;
    logic [31:0]  in_data_i;
    logic [1:0]   in_dparity_i;
    idh_bank_t    bank_o;
    int           num_errors = 0, n_compared = 0;
    always #10 clk_i = ~clk_i;
    idh_hub u_idh_hub (.*);
    idh_far_model u_idh_far_model (.clk_i(clk_i), .srst_i(srst_i),
        .gnt_i(in_gnt_o), .go_i(go), .bad_i(bad), .req_o(in_req_i),
        .data_o(in_data_i), .dpar_o(in_dparity_i));
    // Avalon write, held until waitrequest is seen low
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_write_i <= 1'b1;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask
    task automatic rdreg(input logic [7:0] a);
        @(posedge clk_i);
        avs_read_i <= 1'b1;
        avs_address_i <= a;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rdreg(a);
        `CHK(rd, e)
    endtask
    // Levels may be one register deeper than a pulse
    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic pkt(input logic b);
        @(posedge clk_i);
        go <= 1'b1;
        bad <= b;
        @(posedge clk_i);
        go <= 1'b0;
        rd = 32'h0;
        repeat (20) if (rd[0] !== 1'b1) rdreg(OFS_PKT_STAT);
        `CHK(rd[0], 1'b1)
    endtask
    task automatic end_sim;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        rc(OFS_CTRL, 32'h1);
        rc(8'h40, 32'h0);
        `CHK(bank_o, BANK_RST)
        `CHK(index_hash_enable_o, 1'b0)
        wr(OFS_BANK_EN, 32'h15);
        wr(OFS_HASH, 32'h1);
        wr(OFS_INJECT, 32'h2A95);
        settle;
        `CHK(bank_o, 5'h15)
        `CHK(index_hash_enable_o, 1'b1)
        `CHK(dma_inj_o, 6'h15)
        `CHK(sii_inj_o, 8'hAA)
        wr(OFS_IRQ_ANS, 32'h12A);
        #1 `CHK({irq_ack_o, irq_nack_o, irq_msg_ident_o}, 8'hAA)
        wr(OFS_IRQ_ANS, 32'h215);
        #1 `CHK({irq_ack_o, irq_nack_o, irq_msg_ident_o}, 8'h55)
        wr(OFS_PIO_LO, 32'h89AB_CDEF);
        wr(OFS_PIO_HDR, 32'h0123_4567);
        #1 `CHK({pio_hdr_vld_o, pio_data_o}, {1'b1, 64'h0123_4567_89AB_CDEF})
        wr(OFS_PIO_LO, 32'h1111_2222);
        wr(OFS_INV_HI, 32'h0000_00FF);
        #1 `CHK({xlate_addr_vld_o, pio_data_o}, {1'b1, 64'hFF_1111_2222})
        @(posedge clk_i);
        csr_tx_stall_i <= 1'b1;
        wr(OFS_CSR_TX, 32'hCAFE_0001);
        settle;
        `CHK(csr_tx_o, {1'b1, 32'hCAFE_0001})
        @(posedge clk_i);
        csr_tx_stall_i <= 1'b0;
        @(posedge clk_i);
        #1 `CHK(csr_tx_o.vld, 1'b0)
        @(posedge clk_i);
        csr_rx_i <= '{1'b1, 32'h5A5A_0042};
        @(posedge clk_i);
        csr_rx_i <= '{1'b0, 32'hA5A5_FFBD};
        #1 `CHK(csr_rx_stall_o, 1'b1)
        rc(OFS_CSR_RX, 32'h5A5A_0042);
        #1 `CHK(csr_rx_stall_o, 1'b0)
        // Good credit, then one cycle carrying a bad credit, DMA and SII errors and a syndrome
        @(posedge clk_i);
        {wrack_vld_i, wrack_tag_i, wrack_par_i} <= 6'h2D;
        @(posedge clk_i);
        {wrack_vld_i, wrack_tag_i, wrack_par_i} <= 6'h26;
        {dma_err_i, sii_err_i, syn_vld_i, syn_data_i} <= 19'h0301A;
        @(posedge clk_i);
        {wrack_vld_i, wrack_tag_i, wrack_par_i} <= 6'h13;
        {dma_err_i, sii_err_i, syn_vld_i, syn_data_i} <= 19'h00005;
        rc(OFS_WRACK, 32'h0000_0203);
        rc(OFS_SYNDROME, 32'h1A);
        `CHK(irq_o, 1'b0)
        wr(OFS_MASK, 32'h4000);
        settle;
        `CHK(irq_o, 1'b1)
        rc(OFS_STATUS, 32'h0006_6001);
        wr(OFS_STATUS, 32'h4000);
        settle;
        `CHK(irq_o, 1'b0)
        pkt(1'b0);
        for (int k = 1; k <= PKT_WORDS; k++) rc(OFS_PKT_DATA, 32'hC0DE_0000 + k);
        rc(OFS_STATUS, 32'h0007_2001);
        pkt(1'b1);
        rc(OFS_STATUS, 32'h0007_A001);
        end_sim;
    end
endmodule
